/* src/rx_seg_pkg.sv */
// shared widths, constants and carriers of the segmented receive output
package rx_seg_pkg;
    localparam int SEG_COUNT = 4;
    localparam int DATA_W    = 128;
    localparam int CHAN_W    = 11;
    localparam int MTY_W     = 4;
    localparam int MTY_LOW_W = 3;
    localparam int EXT_W     = 4;
    localparam int CNT_W     = 3;
    localparam int SYNC_W    = 2;

    localparam logic [CNT_W-1:0]  FILL_EMPTY = 3'h0;
    localparam logic [CNT_W-1:0]  FILL_ONE   = 3'h1;
    localparam logic [CNT_W-1:0]  FILL_FULL  = 3'h4;
    localparam logic [CHAN_W-1:0] CHAN_ALL   = 11'h7FF;
    localparam logic [EXT_W-1:0]  EXT_MAX    = 4'hB;
    localparam logic [MTY_LOW_W-1:0] MTY_LOW_ZERO = 3'h0;

    // one word handed over by the packet engine in the core clock domain
    typedef struct packed {
        logic [DATA_W-1:0] word_data;
        logic [CHAN_W-1:0] word_channel;
        logic              word_start;
        logic              word_end;
        logic              word_error;
        logic [MTY_W-1:0]  word_empty;
    } word_s;

    // one segment of the user bus
    typedef struct packed {
        logic              segment_valid_enable;
        logic [DATA_W-1:0] segment_receive_data;
        logic [CHAN_W-1:0] segment_channel_number;
        logic              segment_packet_start;
        logic              segment_packet_end;
        logic              segment_packet_error;
        logic [MTY_W-1:0]  segment_empty_byte_count;
    } seg_s;

    localparam seg_s SEG_IDLE = '0;
endpackage

/* src/reset_sync.sv */
// reset synchroniser: asynchronous assert, two-stage synchronous release
`timescale 1ns/1ps
`default_nettype none
module reset_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic arst,
    output var  logic sync_rst_n
);
    import rx_seg_pkg::*;

    logic [SYNC_W-1:0] stage;

    // release ripples through both stages so it never lands mid-cycle
    always_ff @(posedge clk or negedge rst_n or posedge arst) begin
        if (!rst_n || arst) begin
            stage <= '0;
        end else begin
            stage <= {stage[SYNC_W-2:0], 1'b1};
        end
    end

    assign sync_rst_n = stage[SYNC_W-1];

    property p_reset_assert;
        @(posedge clk) disable iff (!rst_n) arst |=> !sync_rst_n;
    endproperty
    a_reset_assert: assert property (p_reset_assert) else $error("reset not applied");

    property p_reset_release;
        @(posedge clk) disable iff (!rst_n) $rose(sync_rst_n) |-> !$past(arst) && !$past(arst, 2);
    endproperty
    a_reset_release: assert property (p_reset_release) else $error("early reset release");
endmodule
`default_nettype wire

/* src/rx_segment_out.sv */
// receive segmented user bus output: packs words into four segments per user clock
//
// Behaviour
// - user bus outputs timed by user clock
// - path reset synchronised inside the block
// - overflow flag when user clock too slow
// - four 128-bit segments, valid with enable
// - 11-bit channel per segment, with enable
// - channel range follows extent setting
// - enable qualifies every segment output
// - start flag marks packet start
// - end flag marks packet end
// - error flag valid with enable and end
// - empty count valid only on end
// - error forces low empty bits zero
`timescale 1ns/1ps
`default_nettype none
module rx_segment_out (
    input  wire logic                                     core_clk,
    input  wire logic                                     rst_n,
    input  wire logic                                     rx_path_reset,
    input  wire logic                                     user_bus_clk,
    input  wire logic [rx_seg_pkg::EXT_W-1:0]             chan_extent_cfg,
    input  wire logic                                     word_valid,
    input  wire rx_seg_pkg::word_s                        word_in,
    output var  rx_seg_pkg::seg_s [rx_seg_pkg::SEG_COUNT-1:0] segment_out,
    output var  logic                                     receive_overflow_flag
);
    import rx_seg_pkg::*;

    logic                 core_rst_n;
    logic                 uclk_s1;
    logic                 uclk_s2;
    logic                 uclk_s3;
    logic                 ubus_rise;
    logic [EXT_W-1:0]     ext_s1;
    logic [EXT_W-1:0]     ext_s2;
    logic [CHAN_W-1:0]    chan_mask;
    logic [CNT_W-1:0]     fill;
    logic                 drop;
    logic                 ovf_pending;
    seg_s                 packed_word;
    seg_s                 acc [SEG_COUNT];

    // mask of channel bits allowed by the extent setting
    function automatic logic [CHAN_W-1:0] chan_limit(input logic [EXT_W-1:0] ext);
        logic [CHAN_W-1:0] lim;
        lim = CHAN_ALL;
        if (ext < EXT_MAX) begin
            lim = ~(CHAN_ALL << ext);
        end
        return lim;
    endfunction

    // turn an engine word into a clean, qualified segment
    function automatic seg_s pack_seg(input word_s w, input logic [CHAN_W-1:0] lim);
        seg_s s;
        s                          = SEG_IDLE;
        s.segment_valid_enable     = 1'b1;
        s.segment_receive_data     = w.word_data;
        s.segment_channel_number   = w.word_channel & lim;
        s.segment_packet_start     = w.word_start;
        s.segment_packet_end       = w.word_end;
        s.segment_packet_error     = w.word_error & w.word_end;
        if (w.word_end) begin
            s.segment_empty_byte_count = w.word_empty;
            if (w.word_error) begin
                s.segment_empty_byte_count[MTY_LOW_W-1:0] = MTY_LOW_ZERO;
            end
        end
        return s;
    endfunction

    // path reset released only in step with the core clock
    reset_sync u_reset_sync (
        .clk        (core_clk),
        .rst_n      (rst_n),
        .arst       (rx_path_reset),
        .sync_rst_n (core_rst_n)
    );

    // user clock pin sampled twice before its edge is looked for
    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            uclk_s1 <= 1'b0;
            uclk_s2 <= 1'b0;
            uclk_s3 <= 1'b0;
        end else begin
            uclk_s1 <= user_bus_clk;
            uclk_s2 <= uclk_s1;
            uclk_s3 <= uclk_s2;
        end
    end

    assign ubus_rise = uclk_s2 & ~uclk_s3;

    // extent setting is a static pin, synchronised all the same
    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            ext_s1 <= '0;
            ext_s2 <= '0;
        end else begin
            ext_s1 <= chan_extent_cfg;
            ext_s2 <= ext_s1;
        end
    end

    assign chan_mask   = chan_limit(ext_s2);
    assign packed_word = pack_seg(word_in, chan_mask);
    // no room left and no user edge to empty the slots: the word is lost
    assign drop        = word_valid && !ubus_rise && (fill == FILL_FULL);

    // fill level; a word arriving on the edge opens the next beat
    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            fill <= FILL_EMPTY;
        end else if (ubus_rise) begin
            fill <= word_valid ? FILL_ONE : FILL_EMPTY;
        end else if (word_valid && fill != FILL_FULL) begin
            fill <= fill + FILL_ONE;
        end
    end

    // staging slots, filled in ascending order to keep byte order
    for (genvar i = 0; i < SEG_COUNT; i++) begin : g_slot
        always_ff @(posedge core_clk or negedge core_rst_n) begin
            if (!core_rst_n) begin
                acc[i] <= SEG_IDLE;
            end else if (ubus_rise) begin
                acc[i] <= (i == 0 && word_valid) ? packed_word : SEG_IDLE;
            end else if (word_valid && fill == CNT_W'(i)) begin
                acc[i] <= packed_word;
            end
        end

        // outputs move only on the user edge and hold for a whole user cycle
        always_ff @(posedge core_clk or negedge core_rst_n) begin
            if (!core_rst_n) begin
                segment_out[i] <= SEG_IDLE;
            end else if (ubus_rise) begin
                segment_out[i] <= acc[i];
            end
        end
    end

    // loss remembered until the next user edge; a new loss beats the clear
    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            ovf_pending <= 1'b0;
        end else if (drop) begin
            ovf_pending <= 1'b1;
        end else if (ubus_rise) begin
            ovf_pending <= 1'b0;
        end
    end

    // flag shown for one user cycle after any loss in the previous one
    always_ff @(posedge core_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            receive_overflow_flag <= 1'b0;
        end else if (ubus_rise) begin
            receive_overflow_flag <= ovf_pending;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!core_rst_n);

    // longest gap between detected user edges; a slower user clock needs this raised
    localparam int UBUS_GAP_MAX = 8;

    // the next user edge shows the loss on the flag
    sequence s_loss_shown;
        ##[1:UBUS_GAP_MAX] ubus_rise ##1 receive_overflow_flag;
    endsequence

    // a word held in slot zero reaches the bus on the next user edge
    sequence s_next_beat;
        ##[1:UBUS_GAP_MAX] ubus_rise ##1 segment_out[0].segment_valid_enable;
    endsequence

    property p_loss_flagged;
        drop |-> s_loss_shown;
    endproperty
    a_loss_flagged: assert property (p_loss_flagged) else $error("loss not flagged");

    property p_hold_between_edges;
        !ubus_rise |=> $stable(segment_out);
    endproperty
    a_hold_between_edges: assert property (p_hold_between_edges) else $error("bus moved off edge");

    property p_overflow_seen;
        (ubus_rise && ovf_pending) |=> receive_overflow_flag;
    endproperty
    a_overflow_seen: assert property (p_overflow_seen) else $error("overflow not flagged");

    property p_overflow_cause;
        $rose(receive_overflow_flag) |-> $past(ovf_pending) && $past(ubus_rise);
    endproperty
    a_overflow_cause: assert property (p_overflow_cause) else $error("spurious overflow");

    property p_ascending;
        (segment_out[1].segment_valid_enable |-> segment_out[0].segment_valid_enable)
            and (segment_out[2].segment_valid_enable |-> segment_out[1].segment_valid_enable)
            and (segment_out[3].segment_valid_enable |-> segment_out[2].segment_valid_enable);
    endproperty
    a_ascending: assert property (p_ascending) else $error("segments not filled upward");

    property p_word_reaches_bus;
        (ubus_rise && word_valid) |-> s_next_beat;
    endproperty
    a_word_reaches_bus: assert property (p_word_reaches_bus) else $error("word not presented");

    for (genvar k = 0; k < SEG_COUNT; k++) begin : g_chk
        property p_idle_quiet;
            !segment_out[k].segment_valid_enable |-> !segment_out[k].segment_packet_start
                && !segment_out[k].segment_packet_end && !segment_out[k].segment_packet_error;
        endproperty
        a_idle_quiet: assert property (p_idle_quiet) else $error("flag on idle segment");

        property p_chan_range;
            segment_out[k].segment_valid_enable |->
                (segment_out[k].segment_channel_number & ~chan_mask) == '0;
        endproperty
        a_chan_range: assert property (p_chan_range) else $error("channel beyond extent");

        property p_error_on_end;
            segment_out[k].segment_packet_error |-> segment_out[k].segment_packet_end
                && segment_out[k].segment_empty_byte_count[MTY_LOW_W-1:0] == MTY_LOW_ZERO;
        endproperty
        a_error_on_end: assert property (p_error_on_end) else $error("bad error segment");

        property p_empty_only_end;
            !segment_out[k].segment_packet_end |-> segment_out[k].segment_empty_byte_count == '0;
        endproperty
        a_empty_only_end: assert property (p_empty_only_end) else $error("empty count off end");
    end
endmodule
`default_nettype wire

/* tb/user_bus_sink.sv */
// user-side partner: makes the user bus clock and samples the segments
`timescale 1ns/1ps
`default_nettype none
module user_bus_sink (
    input  wire rx_seg_pkg::seg_s [rx_seg_pkg::SEG_COUNT-1:0] segment_out,
    input  wire logic                                        receive_overflow_flag,
    output var  logic                                        user_bus_clk,
    output var  rx_seg_pkg::seg_s [rx_seg_pkg::SEG_COUNT-1:0] beat,
    output var  logic                                        beat_overflow
);
    import rx_seg_pkg::*;
    // free running, phase offset from the core clock; four wide segments
    // per cycle fall short of the six-word burst the bench offers
    initial begin
        user_bus_clk = 1'b0;
        #7;
        forever #80 user_bus_clk = ~user_bus_clk;
    end
    // sampled on the user clock only
    // a disabled segment is thrown away, as user logic would
    always @(posedge user_bus_clk) begin
        for (int i = 0; i < SEG_COUNT; i++) begin
            beat[i] <= segment_out[i].segment_valid_enable ? segment_out[i] : SEG_IDLE;
        end
        beat_overflow <= receive_overflow_flag;
    end
    initial beat = '0;
    initial beat_overflow = 1'b0;
endmodule
`default_nettype wire

/* tb/rx_segmented_user_bus_out_bench.sv */
// self-checking bench of the segmented receive output
`timescale 1ns/1ps
`default_nettype none
module rx_segmented_user_bus_out_bench;
    import rx_seg_pkg::*;
    logic                 core_clk, rst_n, rx_path_reset, user_bus_clk, word_valid;
    logic                 receive_overflow_flag, beat_overflow, ovf;
    logic [EXT_W-1:0]     chan_extent_cfg;
    word_s                word_in;
    word_s                w [6];
    seg_s [SEG_COUNT-1:0] segment_out, beat;
    int                   n_mismatch, cmp_count, cycles;

    rx_segment_out u_rx_segment_out (.core_clk(core_clk), .rst_n(rst_n),
        .rx_path_reset(rx_path_reset), .user_bus_clk(user_bus_clk),
        .chan_extent_cfg(chan_extent_cfg), .word_valid(word_valid), .word_in(word_in),
        .segment_out(segment_out), .receive_overflow_flag(receive_overflow_flag));
    user_bus_sink u_user_bus_sink (.segment_out(segment_out),
        .receive_overflow_flag(receive_overflow_flag), .user_bus_clk(user_bus_clk),
        .beat(beat), .beat_overflow(beat_overflow));

    // core clock scaled down; only its ratio to the user clock matters here
    initial core_clk = 1'b0;
    always #10 core_clk = ~core_clk;
    // hang guard, far above the roughly 160 cycles the run needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles > 20000) begin
            n_mismatch++;
            test_done();
        end
    end

    task test_done;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    function word_s mk(input logic [31:0] d, input logic [CHAN_W-1:0] c,
                       input logic [2:0] f, input logic [MTY_W-1:0] e);
        mk = '{{4{d}}, c, f[2], f[1], f[0], e};
    endfunction
    // expected segment worked out from the word and the extent setting
    function seg_s expect_seg(input word_s x);
        seg_s s;
        logic [11:0] m;
        m = (12'h1 << chan_extent_cfg) - 12'h1;
        s.segment_valid_enable   = 1'b1;
        s.segment_receive_data   = x.word_data;
        s.segment_channel_number = x.word_channel & ((chan_extent_cfg >= EXT_MAX) ? CHAN_ALL : m[10:0]);
        s.segment_packet_start   = x.word_start;
        s.segment_packet_end     = x.word_end;
        s.segment_packet_error   = x.word_end & x.word_error;
        s.segment_empty_byte_count = !x.word_end ? 4'h0 :
            (s.segment_packet_error ? {x.word_empty[3], MTY_LOW_ZERO} : x.word_empty);
        return s;
    endfunction
    // n words back to back from the fifth falling core edge after a user edge, then wait for the capture
    task beat_run(input int n);
        time t;
        @(posedge user_bus_clk);
        t = $time;
        repeat (4) @(negedge core_clk);
        for (int i = 0; i < n; i++) begin
            @(negedge core_clk);
            word_valid = 1'b1;
            word_in = w[i];
        end
        @(negedge core_clk);
        word_valid = 1'b0;
        while ($time < t + 300) @(posedge user_bus_clk);
        #1;
    endtask
    task cmp_beat(input int n);
        for (int i = 0; i < SEG_COUNT; i++) begin
            check(beat[i] === (i < n ? expect_seg(w[i]) : SEG_IDLE), "segment content");
        end
    endtask
    task set_ext(input logic [EXT_W-1:0] e);
        @(negedge core_clk);
        chan_extent_cfg = e;
        repeat (4) @(negedge core_clk);
    endtask

    task two_word_packet;
        set_ext(4'hB);
        w[0] = mk(32'h01234567, 11'h5A3, 3'b100, 4'h0);
        w[1] = mk(32'h89ABCDEF, 11'h7FF, 3'b011, 4'hF);
        beat_run(2);
        cmp_beat(2);
    endtask
    task full_beat_masked;
        set_ext(4'h4);
        w[0] = mk(32'h11112222, 11'h7FF, 3'b101, 4'h5);
        w[1] = mk(32'h33334444, 11'h0F3, 3'b000, 4'h3);
        w[2] = mk(32'h55556666, 11'h3A5, 3'b010, 4'h7);
        w[3] = mk(32'h77778888, 11'h001, 3'b111, 4'h6);
        beat_run(4);
        cmp_beat(4);
    endtask
    task overflow_beat;
        set_ext(4'hF);
        for (int i = 0; i < 6; i++) w[i] = mk(32'hC0DE0000 + i, CHAN_W'(32'h600 + i), 3'b000, 4'h0);
        beat_run(6);
        cmp_beat(4);
        ovf = beat_overflow;
        @(posedge user_bus_clk);
        #1;
        check(ovf === 1'b1 && beat_overflow === 1'b0, "overflow flag timing");
        // the word that met the user edge opens the next beat, not lost
        for (int i = 0; i < SEG_COUNT; i++) begin
            check(beat[i] === (i == 0 ? expect_seg(w[5]) : SEG_IDLE), "edge word carried");
        end
        repeat (3) @(posedge user_bus_clk);
        #1;
        check(beat_overflow === 1'b0, "overflow flag stuck");
    endtask
    task path_reset_mid_run;
        @(negedge core_clk);
        check(segment_out[0].segment_valid_enable === 1'b1, "beat not held");
        rx_path_reset = 1'b1;
        #1;
        check(segment_out === '0 && receive_overflow_flag === 1'b0, "path reset");
        repeat (3) @(negedge core_clk);
        rx_path_reset = 1'b0;
        repeat (5) @(negedge core_clk);
    endtask

    initial begin
        rst_n = 1'b0;
        rx_path_reset = 1'b1;
        word_valid = 1'b0;
        word_in = '0;
        chan_extent_cfg = 4'hB;
        // both resets held while the clocks start
        // lane, reference and transmit resets and clocks sit outside this block;
        // only rst_n and the receive path reset exist here
        repeat (12) @(negedge core_clk);
        check(segment_out === '0 && receive_overflow_flag === 1'b0, "reset value");
        rst_n = 1'b1;
        rx_path_reset = 1'b0;
        repeat (6) @(negedge core_clk);
        two_word_packet();
        full_beat_masked();
        path_reset_mid_run();
        overflow_beat();
        two_word_packet();
        test_done();
    end
endmodule
`default_nettype wire
